// ### core/wcb_pkg.sv
// Purpose: Shared constants and types for the write-combining buffer
// Assumes: One clock, synchronous active-high reset
// Notes:   Line size may be rebuilt as 32 or 64 bytes

package wcb_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int WCB_LINE_BYTES  = 64;  // 32 or 64
  localparam int WCB_CHUNK_BYTES = 8;
  localparam int WCB_CHUNKS      = WCB_LINE_BYTES / WCB_CHUNK_BYTES;
  localparam int WCB_NUM_BUFS    = 4;
  localparam int WCB_ADDR_W      = 32;
  localparam int WCB_FIFO_DEPTH  = 16;
  localparam int WCB_LINE_SH     = $clog2(WCB_LINE_BYTES);
  localparam int WCB_CHUNK_SH    = $clog2(WCB_CHUNK_BYTES);
  localparam int WCB_CIDX_W      = $clog2(WCB_CHUNKS);
  localparam int WCB_BIDX_W      = $clog2(WCB_NUM_BUFS);
  localparam int WCB_LADDR_W     = WCB_ADDR_W - WCB_LINE_SH;
  localparam int WCB_LINE_BITS   = WCB_LINE_BYTES * 8;
  localparam int WCB_CHUNK_BITS  = WCB_CHUNK_BYTES * 8;

  // ************************************************************
  // Types
  // ************************************************************
  typedef logic [WCB_LADDR_W-1:0] wcb_laddr_t;

  typedef struct packed {
    logic [WCB_ADDR_W-1:0]      addr;
    logic [WCB_CHUNK_BITS-1:0]  data;
    logic [WCB_CHUNK_BYTES-1:0] be;
  } wcb_store_t;

  typedef enum logic [1:0] {
    WCB_BUF_FREE  = 2'b00,
    WCB_BUF_OPEN  = 2'b01,
    WCB_BUF_EVICT = 2'b10
  } wcb_buf_st_t;

  typedef enum logic [1:0] {
    WCB_ENG_IDLE  = 2'b00,
    WCB_ENG_BURST = 2'b01,
    WCB_ENG_PART  = 2'b10
  } wcb_eng_st_t;

  typedef enum logic {
    WCB_TXN_PARTIAL = 1'b0,
    WCB_TXN_BURST   = 1'b1
  } wcb_txn_t;

  typedef struct packed {
    wcb_txn_t                  kind;
    logic [WCB_ADDR_W-1:0]     addr;
    logic [WCB_LINE_BITS-1:0]  data;
    logic [WCB_LINE_BYTES-1:0] be;
  } wcb_bus_t;

endpackage

// ### core/wcb_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes:   Pointers carry an extra wrap bit for honest full/empty

`timescale 1ns/1ns

module wcb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              full  = (wr_r[AW] != rd_r[AW]) &&
                            (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire              empty = (wr_r == rd_r);
  wire              push  = in_valid && !full;
  wire              pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_r[AW-1:0]] <= in_data;
  end

endmodule // wcb_fifo

// ### core/wcb_chunk_pick.sv
// Purpose: Find the next 8-byte chunk holding valid bytes
// Assumes: Purely combinational, chunks already sent are masked
// Notes:   Lowest chunk first; any order would be legal on the bus

`timescale 1ns/1ns

module wcb_chunk_pick import wcb_pkg::*; (
  input  wire logic [WCB_LINE_BYTES-1:0] line_bv,
  input  wire logic [WCB_CHUNKS-1:0]     done,
  output logic                           found,
  output logic      [WCB_CIDX_W-1:0]     idx
);
  logic [WCB_CHUNKS-1:0] live;

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int c = WCB_CHUNKS - 1; c >= 0; c--) begin
      live[c] = |line_bv[c*WCB_CHUNK_BYTES +: WCB_CHUNK_BYTES] && !done[c];
      if (live[c]) begin
        found = 1'b1;
        idx   = WCB_CIDX_W'(c);
      end
    end
  end

endmodule // wcb_chunk_pick

// ### core/wcb_top.sv
// Purpose: Write-combining buffer array between store path and bus
// Assumes: One clock, synchronous active-high reset, no software regs
// Notes:   Stores enter through a 16-deep FIFO; evictions leave as
//          one burst per full line or one partial write per chunk holding valid bytes

`timescale 1ns/1ns

module wcb_top import wcb_pkg::*; (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    st_valid,
  output logic                         st_ready,
  input  wire wcb_store_t              st_in,
  input  wire logic                    flush_req,
  output logic                         flush_done,
  output logic                         bus_valid,
  input  wire logic                    bus_ready,
  output wcb_bus_t                     bus_out,
  output logic      [WCB_NUM_BUFS-1:0] buf_busy
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [WCB_BIDX_W-1:0] first_set(
    input logic [WCB_NUM_BUFS-1:0] v
  );
    logic [WCB_BIDX_W-1:0] r;
    r = '0;
    for (int i = WCB_NUM_BUFS - 1; i >= 0; i--) begin
      if (v[i]) r = WCB_BIDX_W'(i);
    end
    return r;
  endfunction

  function automatic wcb_laddr_t line_of(
    input logic [WCB_ADDR_W-1:0] a
  );
    return a[WCB_ADDR_W-1:WCB_LINE_SH];
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  // No snoop port exists: the lines are invisible to coherency
  logic [WCB_LINE_BITS-1:0]  bdat_r  [WCB_NUM_BUFS];
  logic [WCB_LINE_BYTES-1:0] bbv_r   [WCB_NUM_BUFS];
  wcb_laddr_t                bline_r [WCB_NUM_BUFS];
  wcb_buf_st_t               bst_r   [WCB_NUM_BUFS];
  wcb_buf_st_t               bst_nxt [WCB_NUM_BUFS];

  logic [WCB_BIDX_W-1:0]     act_r;
  logic                      act_vld_r;
  logic                      flush_pend_r;
  logic                      flush_done_r;

  // ************************************************************
  // Input FIFO
  // ************************************************************
  logic       fifo_in_rdy;
  logic       head_vld;
  wcb_store_t head;
  logic       pop;

  // Intake closes while a fence drains, so the fence can finish
  assign st_ready = fifo_in_rdy && !flush_pend_r;

  wcb_fifo #(
    .WIDTH ($bits(wcb_store_t)),
    .DEPTH (WCB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (st_valid && !flush_pend_r),
    .in_ready  (fifo_in_rdy),
    .in_data   (st_in),
    .out_valid (head_vld),
    .out_ready (pop),
    .out_data  (head)
  );

  // ************************************************************
  // Lookup and allocation
  // ************************************************************
  logic [WCB_NUM_BUFS-1:0] hit_v;
  logic [WCB_NUM_BUFS-1:0] free_v;
  logic [WCB_NUM_BUFS-1:0] evq_v;
  logic [WCB_NUM_BUFS-1:0] full_v;

  always_comb begin
    for (int i = 0; i < WCB_NUM_BUFS; i++) begin
      hit_v[i]  = (bst_r[i] == WCB_BUF_OPEN) &&
                  (bline_r[i] == line_of(head.addr));
      free_v[i] = (bst_r[i] == WCB_BUF_FREE);
      evq_v[i]  = (bst_r[i] == WCB_BUF_EVICT);
      full_v[i] = &bbv_r[i];
    end
  end

  wire                  hit_any  = |hit_v;
  wire                  free_any = |free_v;
  wire [WCB_BIDX_W-1:0] hit_idx  = first_set(hit_v);
  wire [WCB_BIDX_W-1:0] free_idx = first_set(free_v);
  // A miss with no free buffer leaves the head in place: stall
  assign pop = head_vld && (hit_any || free_any);
  wire                  alloc    = pop && !hit_any;
  wire [WCB_BIDX_W-1:0] tgt      = hit_any ? hit_idx : free_idx;
  wire [WCB_CIDX_W-1:0] head_cix =
    head.addr[WCB_LINE_SH-1:WCB_CHUNK_SH];

  // ************************************************************
  // Byte merge
  // ************************************************************
  logic [WCB_LINE_BITS-1:0]  mdat;
  logic [WCB_LINE_BYTES-1:0] mbv;

  always_comb begin
    mdat = alloc ? '0 : bdat_r[tgt];
    mbv  = alloc ? '0 : bbv_r[tgt];
    for (int b = 0; b < WCB_CHUNK_BYTES; b++) begin
      if (head.be[b]) begin
        // Newest store wins; older bytes are simply overwritten
        mdat[(head_cix*WCB_CHUNK_BYTES+b)*8 +: 8] =
          head.data[b*8 +: 8];
        mbv[head_cix*WCB_CHUNK_BYTES+b] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (pop) begin
      bdat_r[tgt] <= mdat;
      bline_r[tgt] <= line_of(head.addr);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < WCB_NUM_BUFS; i++) bbv_r[i] <= '0;
    end else if (pop) begin
      bbv_r[tgt] <= mbv;
    end
  end

  // ************************************************************
  // Eviction engine
  // ************************************************************
  wcb_eng_st_t             eng_st_r;
  wcb_eng_st_t             eng_st_nxt;
  logic [WCB_BIDX_W-1:0]   eng_buf_r;
  logic [WCB_BIDX_W-1:0]   eng_buf_nxt;
  logic [WCB_CHUNKS-1:0]   done_r;
  logic [WCB_CHUNKS-1:0]   done_nxt;
  logic                    bus_vld_r;
  logic                    bus_vld_nxt;
  wcb_bus_t                bus_r;
  wcb_bus_t                bus_nxt;
  logic                    eng_free;
  logic                    pick_found;
  logic [WCB_CIDX_W-1:0]   pick_idx;

  // Limitation: a reopened line may sit in two buffers, and the lower
  // index leaves first; weak ordering allows it, so a store issuer that
  // needs memory in order must fence between the two writes
  // The lowest-index queued buffer goes first; allocation age is not kept
  wire [WCB_BIDX_W-1:0] ev_sel = first_set(evq_v);
  wire                  ev_any = |evq_v;
  wire                  slot   = !bus_vld_r || bus_ready;

  wcb_chunk_pick u_pick (
    .line_bv (bbv_r[eng_buf_r]),
    .done    (done_r),
    .found   (pick_found),
    .idx     (pick_idx)
  );

  always_comb begin
    eng_st_nxt  = eng_st_r;
    eng_buf_nxt = eng_buf_r;
    done_nxt    = done_r;
    bus_vld_nxt = bus_vld_r && !bus_ready;
    bus_nxt     = bus_r;
    eng_free    = 1'b0;
    case (eng_st_r)
      WCB_ENG_IDLE: begin
        if (ev_any && !bus_vld_r) begin
          eng_buf_nxt = ev_sel;
          done_nxt    = '0;
          if (full_v[ev_sel]) begin
            // Whole line as one beat: chunk order is moot
            bus_nxt.kind = WCB_TXN_BURST;
            bus_nxt.addr = {bline_r[ev_sel],
                            WCB_LINE_SH'(0)};
            bus_nxt.data = bdat_r[ev_sel];
            bus_nxt.be   = '1;
            bus_vld_nxt  = 1'b1;
            eng_st_nxt   = WCB_ENG_BURST;
          end else begin
            eng_st_nxt   = WCB_ENG_PART;
          end
        end
      end
      WCB_ENG_BURST: begin
        if (bus_ready) begin
          eng_free   = 1'b1;
          eng_st_nxt = WCB_ENG_IDLE;
        end
      end
      WCB_ENG_PART: begin
        if (slot) begin
          if (pick_found) begin
            // Each chunk is sent at most once, so the count is bounded
            done_nxt[pick_idx] = 1'b1;
            bus_nxt.kind = WCB_TXN_PARTIAL;
            bus_nxt.addr = {bline_r[eng_buf_r], pick_idx,
                            WCB_CHUNK_SH'(0)};
            bus_nxt.data = '0;
            bus_nxt.be   = '0;
            // All valid bytes of the chunk travel in one beat
            bus_nxt.data[WCB_CHUNK_BITS-1:0] =
              bdat_r[eng_buf_r][pick_idx*WCB_CHUNK_BITS +:
                                WCB_CHUNK_BITS];
            bus_nxt.be[WCB_CHUNK_BYTES-1:0] =
              bbv_r[eng_buf_r][pick_idx*WCB_CHUNK_BYTES +:
                               WCB_CHUNK_BYTES];
            bus_vld_nxt  = 1'b1;
          end else begin
            eng_free   = 1'b1;
            eng_st_nxt = WCB_ENG_IDLE;
          end
        end
      end
      default: begin
        eng_st_nxt = WCB_ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      eng_st_r  <= WCB_ENG_IDLE;
      eng_buf_r <= '0;
      done_r    <= '0;
      bus_vld_r <= 1'b0;
      bus_r     <= '0;
    end else begin
      eng_st_r  <= eng_st_nxt;
      eng_buf_r <= eng_buf_nxt;
      done_r    <= done_nxt;
      bus_vld_r <= bus_vld_nxt;
      bus_r     <= bus_nxt;
    end
  end

  assign bus_valid = bus_vld_r;
  assign bus_out   = bus_r;

  // ************************************************************
  // Buffer states
  // ************************************************************
  wire fifo_dry = !head_vld;
  wire drain    = flush_pend_r && fifo_dry;

  always_comb begin
    for (int i = 0; i < WCB_NUM_BUFS; i++) begin
      bst_nxt[i] = bst_r[i];
      if (bst_r[i] == WCB_BUF_OPEN) begin
        // A filled line goes out at once; no reason to wait
        if (full_v[i]) bst_nxt[i] = WCB_BUF_EVICT;
        if (drain) bst_nxt[i] = WCB_BUF_EVICT;
        // Moving on to a new line closes the one being filled
        if (alloc && act_vld_r && act_r == WCB_BIDX_W'(i))
          bst_nxt[i] = WCB_BUF_EVICT;
      end
      if (alloc && free_idx == WCB_BIDX_W'(i))
        bst_nxt[i] = WCB_BUF_OPEN;
      if (eng_free && eng_buf_r == WCB_BIDX_W'(i))
        bst_nxt[i] = WCB_BUF_FREE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < WCB_NUM_BUFS; i++) bst_r[i] <= WCB_BUF_FREE;
    end else begin
      for (int i = 0; i < WCB_NUM_BUFS; i++) bst_r[i] <= bst_nxt[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      act_r     <= '0;
      act_vld_r <= 1'b0;
    end else if (alloc) begin
      act_r     <= free_idx;
      act_vld_r <= 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < WCB_NUM_BUFS; i++) begin
      buf_busy[i] = (bst_r[i] != WCB_BUF_FREE);
    end
  end

  // ************************************************************
  // Serializing event
  // ************************************************************
  // Done only when queue, buffers and bus holding stage are empty
  wire all_clear = fifo_dry && !(|buf_busy) &&
                   (eng_st_r == WCB_ENG_IDLE) && !bus_vld_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      flush_pend_r <= 1'b0;
      flush_done_r <= 1'b0;
    end else begin
      // A new request in the finishing cycle keeps the fence open
      flush_pend_r <= flush_req ||
                      (flush_pend_r && !all_clear);
      flush_done_r <= flush_pend_r && all_clear && !flush_req;
    end
  end

  assign flush_done = flush_done_r;

endmodule // wcb_top

// ### verif/wcb_top_assertions.sv
// Purpose: Port checks for the write-combining buffer
// Assumes: One clock, srst synchronous active high
// Notes:   Bound to wcb_top from the testbench top file
`timescale 1ns/1ns

module wcb_top_assertions import wcb_pkg::*; (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire logic                    st_valid,
  input wire logic                    st_ready,
  input wire wcb_store_t              st_in,
  input wire logic                    flush_req,
  input wire logic                    flush_done,
  input wire logic                    bus_valid,
  input wire logic                    bus_ready,
  input wire wcb_bus_t                bus_out,
  input wire logic [WCB_NUM_BUFS-1:0] buf_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // *****
  // Run of partial beats to one line
  // *****
  logic [WCB_LADDR_W-1:0] run_line_r;
  logic [3:0]             run_cnt_r;
  wire take = bus_valid && bus_ready;
  wire part = bus_out.kind == WCB_TXN_PARTIAL;
  wire [WCB_LADDR_W-1:0] beat_line = bus_out.addr[WCB_ADDR_W-1:WCB_LINE_SH];

  always_ff @(posedge clk) begin
    if (srst || (take && !part)) begin
      run_cnt_r  <= 4'h0;
      run_line_r <= '1;
    end else if (take) begin
      run_cnt_r  <= (beat_line == run_line_r) ? run_cnt_r + 4'h1 : 4'h1;
      run_line_r <= beat_line;
    end
  end

  // *****
  // Assertions
  // *****
  chk_beat_hold: assert property (
    bus_valid && !bus_ready |=> bus_valid && $stable(bus_out))
    else $error("beat changed before it was taken");
  chk_burst_whole: assert property (
    bus_valid && !part |-> (&bus_out.be) &&
      bus_out.addr[WCB_LINE_SH-1:0] == '0)
    else $error("burst not a whole aligned line");
  chk_part_chunk: assert property (
    bus_valid && part |-> bus_out.addr[WCB_CHUNK_SH-1:0] == '0 &&
      bus_out.be[WCB_LINE_BYTES-1:WCB_CHUNK_BYTES] == '0)
    else $error("partial beat wider than one chunk");
  chk_part_live: assert property (
    bus_valid && part |-> bus_out.be[WCB_CHUNK_BYTES-1:0] != '0)
    else $error("partial beat with no valid byte");
  chk_part_count: assert property (
    run_cnt_r <= WCB_CHUNKS)
    else $error("too many partial writes for one line");
  chk_fence_gate: assert property (
    flush_req |=> !st_ready)
    else $error("store taken while fence pending");
  chk_fence_bound: assert property (
    flush_req |-> ##[1:1000] flush_done)
    else $error("fence never completed");
  chk_done_idle: assert property (
    flush_done |-> !bus_valid && buf_busy == '0)
    else $error("fence done with data still held");
  chk_done_pulse: assert property (
    flush_done |=> !flush_done)
    else $error("fence done longer than one cycle");
endmodule // wcb_top_assertions

// ### verif/wcb_bus_agent.sv
// Purpose: Bus agent answering eviction beats
// Assumes: Ready is a registered level sampled with bus_valid
// Notes:   pace 0 prompt, 1 four waits per beat, 2 halted
`timescale 1ns/1ns

module wcb_bus_agent (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] pace,
  input  wire logic       bus_valid,
  output logic            bus_ready
);
  logic [1:0] wait_r;
  wire take = bus_valid && bus_ready;

  // Ready drops after each beat, so no beat is taken on a stale level
  always_ff @(posedge clk) begin
    if (srst || take) begin
      wait_r    <= 2'h0;
      bus_ready <= 1'b0;
    end else begin
      wait_r    <= (bus_valid && wait_r != 2'h3) ? wait_r + 2'h1 : wait_r;
      bus_ready <= bus_valid &&
                   (pace == 2'h0 || (pace == 2'h1 && wait_r == 2'h3));
    end
  end
endmodule // wcb_bus_agent

// ### verif/tb_wcb_top.sv
// Purpose: Self-checking bench for the write-combining buffer
// Assumes: 100 ns clock, inputs driven 10 ns after the rising edge
// Notes:   Bytes seen on the bus are compared with a byte model
`timescale 1ns/1ns

module tb_wcb_top import wcb_pkg::*;;
  logic                    clk;
  logic                    srst;
  logic                    st_valid;
  logic                    st_ready;
  wcb_store_t              st_in;
  logic                    flush_req;
  logic                    flush_done;
  logic                    bus_valid;
  logic                    bus_ready;
  wcb_bus_t                bus_out;
  logic [WCB_NUM_BUFS-1:0] buf_busy;
  logic [1:0]              pace;
  logic [7:0]              seq;
  int                      miscompares;
  int                      total_checks;
  int                      n_burst;
  int                      n_part;
  logic [7:0]              exp_mem [int unsigned];
  logic [7:0]              got_mem [int unsigned];

  wcb_top DUT (.clk(clk), .srst(srst), .st_valid(st_valid),
    .st_ready(st_ready), .st_in(st_in), .flush_req(flush_req),
    .flush_done(flush_done), .bus_valid(bus_valid),
    .bus_ready(bus_ready), .bus_out(bus_out), .buf_busy(buf_busy));
  wcb_bus_agent far_end (.clk(clk), .srst(srst), .pace(pace),
    .bus_valid(bus_valid), .bus_ready(bus_ready));

  always #50 clk = ~clk;

  // *****
  // Bus monitor and common tasks
  // *****
  // Sampled mid-cycle, where a beat stands settled before its take edge
  always @(negedge clk) begin
    if (bus_valid && bus_ready) begin
      if (bus_out.kind == WCB_TXN_BURST) n_burst++;
      else n_part++;
      for (int b = 0; b < WCB_LINE_BYTES; b++) begin
        if (bus_out.be[b]) got_mem[bus_out.addr + b] = bus_out.data[8*b +: 8];
      end
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("mismatch at %0t: no progress on %s", $time, what);
    complete_run();
  endtask

  // Leaves st_valid high so back-to-back stores never retoggle it
  task automatic put_store(input logic [31:0] a, input logic [7:0] be);
    logic ok;
    int   n;
    seq++;
    st_in.addr = a;
    st_in.be = be;
    for (int b = 0; b < 8; b++) st_in.data[8*b +: 8] = 8'(a[7:0] + b) ^ seq;
    st_valid = 1'b1;
    ok = 1'b0;
    n = 0;
    while (!ok) begin
      @(negedge clk);
      ok = st_ready;
      n++;
      @(posedge clk);
      #10;
      if (n > 400) hang("store");
    end
    for (int b = 0; b < 8; b++) begin
      if (be[b]) exp_mem[a + b] = 8'(a[7:0] + b) ^ seq;
    end
  endtask

  task automatic fence();
    int n;
    st_valid = 1'b0;
    flush_req = 1'b1;
    @(posedge clk);
    #10;
    flush_req = 1'b0;
    n = 0;
    while (flush_done !== 1'b1) begin
      @(posedge clk);
      #10;
      n++;
      if (n > 2000) hang("fence");
    end
  endtask

  task automatic verify(input int bursts, input int parts);
    logic [7:0] g;
    check(n_burst, bursts, "burst beats");
    check(n_part, parts, "partial beats");
    check(got_mem.size(), exp_mem.size(), "bytes written");
    foreach (exp_mem[k]) begin
      g = got_mem.exists(k) ? got_mem[k] : 8'hXX;
      check(g, exp_mem[k], "byte");
    end
    exp_mem.delete();
    got_mem.delete();
    n_burst = 0;
    n_part = 0;
  endtask

  // *****
  // Scenarios
  // *****
  task automatic test_idle_fence();
    fence();
    verify(0, 0);
    $display("test_idle_fence done");
  endtask

  task automatic test_full_line();
    put_store(32'h0000_1010, 8'h0F);
    for (int c = 0; c < 8; c++) put_store(32'h0000_1000 + 8 * c, 8'hFF);
    fence();
    verify(1, 0);
    $display("test_full_line done");
  endtask

  task automatic test_partial();
    pace = 2'h1;
    put_store(32'h0000_2000, 8'h81);
    put_store(32'h0000_2018, 8'h0F);
    put_store(32'h0000_2018, 8'hF0);
    put_store(32'h0000_2038, 8'h10);
    put_store(32'h0000_2038, 8'h10);
    fence();
    verify(0, 3);
    pace = 2'h0;
    $display("test_partial done");
  endtask

  // A store to a new line must close the partly filled one without a fence
  task automatic test_switch();
    put_store(32'h0000_6008, 8'h3C);
    put_store(32'h0000_6048, 8'hFF);
    st_valid = 1'b0;
    repeat (20) @(posedge clk);
    #10;
    check(n_part, 1, "line closed by next line");
    fence();
    verify(0, 2);
    $display("test_switch done");
  endtask

  task automatic test_stall();
    pace = 2'h2;
    fork
      begin
        for (int i = 0; i < 56; i++) put_store(32'h0000_4000 + 8 * i, 8'hFF);
      end
      begin
        repeat (150) @(posedge clk);
        @(negedge clk);
        check(st_ready, 1'b0, "stores refused");
        check(buf_busy, 4'hF, "all buffers busy");
        @(posedge clk);
        #10;
        pace = 2'h0;
      end
    join
    fence();
    verify(7, 0);
    $display("test_stall done");
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    st_valid = 1'b0;
    st_in = '0;
    flush_req = 1'b0;
    pace = 2'h0;
    seq = 8'h00;
    miscompares = 0;
    total_checks = 0;
    n_burst = 0;
    n_part = 0;
    repeat (16) @(posedge clk);
    #10;
    srst = 1'b0;
    test_idle_fence();
    test_full_line();
    test_partial();
    test_switch();
    test_stall();
    complete_run();
  end
endmodule // tb_wcb_top

bind wcb_top wcb_top_assertions chk (.clk(clk), .srst(srst),
  .st_valid(st_valid), .st_ready(st_ready), .st_in(st_in),
  .flush_req(flush_req), .flush_done(flush_done), .bus_valid(bus_valid),
  .bus_ready(bus_ready), .bus_out(bus_out), .buf_busy(buf_busy));
